// ==== spi_host_port_pkg.sv ====
// Constants and types shared by the serial host port design
//
// What this block does
// - Device is slave only; master supplies every clock edge and starts transfers.
// - Clock mode 0, idle low, sample on rising edge, most significant bit first.
// - Attention asserts while data is queued or an odd number of taken bytes are not yet clocked out.
// - Attention pin is actively driven and low means data pending.
// - While selected and clocked, one output bit per clock cycle.
// - Serial output released to high impedance whenever select is high.
// - Port carries only unescaped API frames, no transparent streaming.
// - Bytes outside a valid frame are filler and are discarded.
// - Outgoing and incoming frames may overlap in full duplex.
// - Sleep request input, when a peripheral, controls pin sleep.
// - Otherwise select controls pin sleep: low wakes, high sleeps.
// - With neither pin a peripheral the device stays awake.
// - With nothing pending the output repeats the last sent bit.
// - With both ports enabled, the first port given input wins until reset.
package spi_host_port_pkg;

    // ****************************************************************
    // Framing
    // ****************************************************************
    localparam int byte_width = 8;
    localparam logic [7:0] frame_delimiter = 8'h7E;
    localparam logic [1:0] api_framing_setting = 2'h1;
    localparam logic [15:0] checksum_bytes = 16'h0001;

    // ****************************************************************
    // Crossing and reset values
    // ****************************************************************
    localparam int sys_sync_count = 5;
    localparam int sync_select_idx = 0;
    localparam int sync_sleep_idx = 1;
    localparam int sync_ack_idx = 2;
    localparam int sync_done_idx = 3;
    localparam int sync_rx_idx = 4;
    localparam logic [2:0] bit_index_reset = 3'h0;
    localparam logic [2:0] bit_index_last = 3'h7;
    localparam logic [7:0] byte_reset = 8'h00;

    // ****************************************************************
    // State types
    // ****************************************************************
    typedef enum logic [3:0] {
        port_undecided = 4'h1,
        port_spi = 4'h2,
        port_uart = 4'h4,
        port_off = 4'h8
    } port_state_t;

    typedef enum logic [3:0] {
        frame_hunt = 4'h1,
        frame_len_hi = 4'h2,
        frame_len_lo = 4'h4,
        frame_body = 4'h8
    } frame_state_t;

endpackage

// ==== sync_two_flop.sv ====
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync_two_flop (
    input wire logic clk,
    input wire logic resetn,
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== spi_slave_host_port.sv ====
// Serial slave host port: link shifter, crossings, framing, port choice, sleep
`timescale 1ns/1ps
module spi_slave_host_port (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    output logic attention_request_n,
    input wire logic general_io_eight,
    input wire logic [spi_host_port_pkg::byte_width-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx_queued,
    output logic [spi_host_port_pkg::byte_width-1:0] rx_data,
    output logic rx_valid,
    input wire logic serial_out_pin_function,
    input wire logic serial_in_pin_function,
    input wire logic select_pin_function,
    input wire logic clock_pin_function,
    input wire logic attention_pin_function,
    input wire logic sleep_pin_function,
    input wire logic pin_sleep_mode,
    input wire logic uart_enabled,
    input wire logic uart_input,
    output logic spi_port_active,
    output logic uart_port_active,
    output logic pin_sleep
);
    import spi_host_port_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic link_rst_n;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_byte;
    logic rx_tog;
    logic [2:0] tx_bit;
    logic [7:0] tx_cur;
    logic tx_last;
    logic tx_sending;
    logic tx_ack;
    logic tx_done;
    logic req_meta;
    logic req_link;
    logic tx_pend;
    logic [7:0] tx_first;
    logic tx_bit_now;
    logic [7:0] tx_hold;
    logic tx_req;
    logic [sys_sync_count-1:0] sync_in;
    logic [sys_sync_count-1:0] sync_out;
    logic rx_seen;
    logic rx_new;
    logic spi_enabled;
    logic spi_live;
    logic attn;
    logic sleep_now;
    logic [15:0] frame_left;
    port_state_t port_state;
    port_state_t next_port_state;
    frame_state_t frame_state;
    frame_state_t next_frame_state;
    logic in_frame;
    logic [15:0] next_frame_left;

    // ****************************************************************
    // Link domain: receive on rising edges
    // ****************************************************************
    // Select high ends every byte in progress; the link clock may stop outside frames
    assign link_rst_n = resetn & ~select_n;

    always_ff @(posedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_bit <= bit_index_reset;
            rx_shift <= byte_reset;
        end else begin
            rx_bit <= rx_bit + 3'h1;
            rx_shift <= {rx_shift[6:0], serial_in};
        end
    end

    always_ff @(posedge serial_clk or negedge resetn) begin
        if (!resetn) begin
            rx_byte <= byte_reset;
            rx_tog <= 1'b0;
        end else if (!select_n && rx_bit == bit_index_last) begin
            rx_byte <= {rx_shift[6:0], serial_in};
            rx_tog <= ~rx_tog;
        end
    end

    // ****************************************************************
    // Link domain: transmit after falling edges
    // ****************************************************************
    // Request toggle is synchronised on falling edges so the first bit never changes mid-bit
    always_ff @(negedge serial_clk or negedge resetn) begin
        if (!resetn) begin
            req_meta <= 1'b0;
            req_link <= 1'b0;
        end else begin
            req_meta <= tx_req;
            req_link <= req_meta;
        end
    end

    // Held byte is stable while a request is outstanding, so it is safe to read here
    assign tx_pend = (req_link != tx_ack) && spi_live;
    assign tx_first = tx_pend ? tx_hold : {8{tx_last}};
    assign tx_bit_now = (tx_bit == bit_index_reset) ? tx_first[7] : tx_cur[3'h7 - tx_bit];

    always_ff @(negedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_bit <= bit_index_reset;
            tx_cur <= byte_reset;
            tx_sending <= 1'b0;
        end else begin
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == bit_index_reset) begin
                tx_cur <= tx_first;
                tx_sending <= tx_pend;
            end
        end
    end

    // Toggles survive select so no byte handshake is lost across frames
    always_ff @(negedge serial_clk or negedge resetn) begin
        if (!resetn) begin
            tx_last <= 1'b0;
            tx_ack <= 1'b0;
            tx_done <= 1'b0;
        end else if (!select_n) begin
            tx_last <= tx_bit_now;
            if (tx_bit == bit_index_reset && tx_pend) begin
                tx_ack <= ~tx_ack;
            end
            if (tx_bit == bit_index_last && tx_sending) begin
                tx_done <= ~tx_done;
            end
        end
    end

    assign serial_out = tx_bit_now;
    assign serial_out_en = ~select_n & spi_live & serial_out_pin_function;

    // ****************************************************************
    // Crossings into the system clock
    // ****************************************************************
    assign sync_in[sync_select_idx] = select_n;
    assign sync_in[sync_sleep_idx] = general_io_eight;
    assign sync_in[sync_ack_idx] = tx_ack;
    assign sync_in[sync_done_idx] = tx_done;
    assign sync_in[sync_rx_idx] = rx_tog;

    genvar gi;
    generate
        for (gi = 0; gi < sys_sync_count; gi = gi + 1) begin : g_sync
            sync_two_flop u_sync (
                .clk(sys_clk),
                .resetn(resetn),
                .d(sync_in[gi]),
                .q(sync_out[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Transmit handshake and attention
    // ****************************************************************
    assign tx_ready = (tx_req == sync_out[sync_ack_idx]) && spi_live;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_hold <= byte_reset;
            tx_req <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            tx_hold <= tx_data;
            tx_req <= ~tx_req;
        end
    end

    // Asserted while an odd number of taken bytes have not fully left the shifter
    assign attn = tx_queued | (tx_req != sync_out[sync_done_idx]);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            attention_request_n <= 1'b1;
        end else begin
            attention_request_n <= ~(attn & attention_pin_function & spi_live);
        end
    end

    // ****************************************************************
    // Port selection
    // ****************************************************************
    assign spi_enabled = serial_out_pin_function & serial_in_pin_function
        & select_pin_function & clock_pin_function;
    assign spi_live = (port_state == port_spi) || (port_state == port_undecided);
    assign spi_port_active = (port_state == port_spi);
    assign uart_port_active = (port_state == port_uart) || (port_state == port_undecided)
        || (port_state == port_off);

    always_comb begin
        next_port_state = port_state;
        case (port_state)
            port_undecided: begin
                if (!spi_enabled) begin
                    next_port_state = port_off;
                end else if (rx_new) begin
                    next_port_state = port_spi;
                end else if (uart_input && uart_enabled) begin
                    next_port_state = port_uart;
                end else if (!uart_enabled) begin
                    next_port_state = port_spi;
                end
            end
            port_spi: next_port_state = port_spi;
            port_uart: next_port_state = port_uart;
            port_off: next_port_state = port_off;
            default: next_port_state = port_undecided;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            port_state <= port_undecided;
        end else begin
            port_state <= next_port_state;
        end
    end

    // ****************************************************************
    // Frame filter
    // ****************************************************************
    // Only bytes inside a delimited, length-counted frame are passed on
    assign rx_new = (sync_out[sync_rx_idx] != rx_seen) && spi_enabled
        && (port_state != port_uart);

    always_comb begin
        next_frame_state = frame_state;
        next_frame_left = frame_left;
        in_frame = 1'b0;
        if (rx_new) begin
            case (frame_state)
                frame_hunt: begin
                    if (rx_byte == frame_delimiter) begin
                        next_frame_state = frame_len_hi;
                        in_frame = 1'b1;
                    end
                end
                frame_len_hi: begin
                    next_frame_left = {rx_byte, 8'h00};
                    next_frame_state = frame_len_lo;
                    in_frame = 1'b1;
                end
                frame_len_lo: begin
                    next_frame_left = {frame_left[15:8], rx_byte} + checksum_bytes;
                    next_frame_state = frame_body;
                    in_frame = 1'b1;
                end
                frame_body: begin
                    next_frame_left = frame_left - 16'h0001;
                    in_frame = 1'b1;
                    if (frame_left == 16'h0001) begin
                        next_frame_state = frame_hunt;
                    end
                end
                default: next_frame_state = frame_hunt;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_seen <= 1'b0;
            frame_state <= frame_hunt;
            frame_left <= 16'h0000;
            rx_data <= byte_reset;
            rx_valid <= 1'b0;
        end else begin
            rx_seen <= sync_out[sync_rx_idx];
            frame_state <= next_frame_state;
            frame_left <= next_frame_left;
            rx_valid <= in_frame;
            if (in_frame) begin
                rx_data <= rx_byte;
            end
        end
    end

    // ****************************************************************
    // Pin sleep
    // ****************************************************************
    assign sleep_now = pin_sleep_mode & (sleep_pin_function ? sync_out[sync_sleep_idx]
        : (select_pin_function & sync_out[sync_select_idx]));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_sleep <= 1'b0;
        end else begin
            pin_sleep <= sleep_now;
        end
    end
endmodule

// ==== spi_slave_host_port_chk.sv ====
// Port-level assertions for the serial slave host port
`timescale 1ns/1ps
module spi_slave_host_port_chk (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic select_n,
    input wire logic serial_out_en,
    input wire logic attention_request_n,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic general_io_eight,
    input wire logic serial_out_pin_function,
    input wire logic select_pin_function,
    input wire logic attention_pin_function,
    input wire logic sleep_pin_function,
    input wire logic pin_sleep_mode,
    input wire logic spi_port_active,
    input wire logic uart_port_active,
    input wire logic pin_sleep
);
    // ****************************************************************
    // Properties, all in the system clock domain
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_out_released: assert property (serial_out_en |-> !select_n && serial_out_pin_function)
        else $error("serial output driven while released");
    a_out_live: assert property (
        !select_n && serial_out_pin_function && spi_port_active |-> serial_out_en)
        else $error("serial output not driven while selected");
    a_attn_unused: assert property (!attention_pin_function [*2] |-> attention_request_n)
        else $error("attention low while unused");
    a_attn_on_take: assert property (
        tx_valid && tx_ready && attention_pin_function |-> ##[1:3] !attention_request_n)
        else $error("attention not raised for queued byte");
    a_port_exclusive: assert property (spi_port_active |-> !uart_port_active)
        else $error("both ports active");
    // Sync flops plus the sleep register give three cycles of lag
    a_sleep_request: assert property (
        (pin_sleep_mode && sleep_pin_function && $stable(general_io_eight)) [*5]
        |-> pin_sleep == general_io_eight)
        else $error("sleep does not follow request pin");
    a_sleep_select: assert property (
        (pin_sleep_mode && !sleep_pin_function && select_pin_function && $stable(select_n)) [*5]
        |-> pin_sleep == select_n)
        else $error("sleep does not follow select");
    a_awake_neither: assert property (
        (!sleep_pin_function && !select_pin_function) [*3] |-> !pin_sleep)
        else $error("sleep with no sleep pin");
    c_rx_byte: cover property (rx_valid);
    c_attn: cover property ($fell(attention_request_n));
    c_sleep: cover property (pin_sleep);
endmodule
bind spi_slave_host_port spi_slave_host_port_chk spi_slave_host_port_chk_i (
    .sys_clk(sys_clk), .resetn(resetn), .select_n(select_n), .serial_out_en(serial_out_en),
    .attention_request_n(attention_request_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .general_io_eight(general_io_eight),
    .serial_out_pin_function(serial_out_pin_function), .select_pin_function(select_pin_function),
    .attention_pin_function(attention_pin_function), .sleep_pin_function(sleep_pin_function),
    .pin_sleep_mode(pin_sleep_mode), .spi_port_active(spi_port_active),
    .uart_port_active(uart_port_active), .pin_sleep(pin_sleep));

// ==== spi_master_model.sv ====
// Behavioural serial master that selects and clocks the host port
`timescale 1ns/1ps
module spi_master_model (
    output logic serial_clk,
    output logic select_n,
    output logic serial_in,
    input wire logic miso
);
    // ****************************************************************
    // Link driving, 12 ns period, clock still outside bytes
    // ****************************************************************
    int gap = 0;
    initial begin
        serial_clk = 1'b0;
        select_n = 1'b1;
        serial_in = 1'b1;
    end
    // Released data line floats to its pull-up level
    task automatic sel(input logic lvl);
        #6 select_n = lvl;
        serial_in = 1'b1;
    endtask
    // Data set while clock low, both lines sampled on the rise
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_in = tx[i];
            #6 serial_clk = 1'b1;
            rx[i] = miso;
            #6 serial_clk = 1'b0;
        end
        // Slow mode: hold the clock low between bytes, data meaningless meanwhile
        if (gap > 0) begin
            #1 serial_in = ~serial_in;
            #(gap - 1);
        end
    endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the serial slave host port
`timescale 1ns/1ps
`define check(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    $display("unexpected %s expected %h seen %h", nm, exp, got); mismatches++; end end
module testbench;
    // ****************************************************************
    // Clock, reset, instances and scenarios
    // ****************************************************************
    logic sys_clk = 1'b0, resetn = 1'b0, tx_valid = 1'b0, tx_queued = 1'b0, gio = 1'b0;
    logic out_f = 1'b1, in_f = 1'b1, sel_f = 1'b1, clk_f = 1'b1, attn_f = 1'b1, slp_f = 1'b0;
    logic mode = 1'b0, uart_en = 1'b0, uart_in = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data;
    logic [7:0] rxq[$];
    logic sclk, ssn, mosi, miso, sout, sout_en, attn_n, tx_ready, rx_valid, spi_act, uart_act, slp;
    int checks_done = 0, mismatches = 0, cycles = 0;
    // No other driver on the line here; a released line rests high
    assign miso = sout_en ? sout : 1'b1;
    spi_master_model master_i (.serial_clk(sclk), .select_n(ssn), .serial_in(mosi), .miso(miso));
    spi_slave_host_port spi_slave_host_port_i (.sys_clk(sys_clk), .resetn(resetn),
        .serial_clk(sclk), .select_n(ssn), .serial_in(mosi), .serial_out(sout),
        .serial_out_en(sout_en), .attention_request_n(attn_n), .general_io_eight(gio),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_queued(tx_queued),
        .rx_data(rx_data), .rx_valid(rx_valid), .serial_out_pin_function(out_f),
        .serial_in_pin_function(in_f), .select_pin_function(sel_f), .clock_pin_function(clk_f),
        .attention_pin_function(attn_f), .sleep_pin_function(slp_f), .pin_sleep_mode(mode),
        .uart_enabled(uart_en), .uart_input(uart_in), .spi_port_active(spi_act),
        .uart_port_active(uart_act), .pin_sleep(slp));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // Registered outputs are read at the falling edge, where they have settled
    always @(negedge sys_clk) begin
        cycles++;
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx_data);
        end
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic offer(input logic [7:0] d);
        @(negedge sys_clk);
        // Ready only moves on rising edges, so a high level here means the next edge takes it
        while (tx_ready !== 1'b1) @(negedge sys_clk);
        tx_data = d;
        tx_valid = 1'b1;
        @(negedge sys_clk);
        tx_valid = 1'b0;
    endtask
    task automatic t_send();
        logic [7:0] b;
        bit hit = 0;
        `check("idle attention", 1'b1, attn_n)
        offer(8'hC1);
        `check("ready after take", 1'b0, tx_ready)
        @(negedge sys_clk);
        `check("attention low", 1'b0, attn_n)
        master_i.sel(1'b0);
        @(negedge sys_clk);
        `check("out enable", 1'b1, sout_en)
        for (int k = 0; k < 4 && !hit; k++) begin
            master_i.xfer(8'hFF, 8, b);
            hit = (b === 8'hC1);
        end
        `check("byte msb first", 1'b1, hit)
        master_i.xfer(8'hFF, 8, b);
        `check("idle repeats bit", 8'hFF, b)
        master_i.sel(1'b1);
        repeat (8) @(negedge sys_clk);
        `check("attention released", 1'b1, attn_n)
        `check("out released", 1'b0, sout_en)
        `check("spi chosen", 1'b1, spi_act)
        tx_queued = 1'b1;
        repeat (2) @(negedge sys_clk);
        `check("attention on queued", 1'b0, attn_n)
        tx_queued = 1'b0;
        repeat (2) @(negedge sys_clk);
        `check("attention after queue", 1'b1, attn_n)
    endtask
    task automatic t_duplex();
        logic [7:0] fr[7] = '{8'h55, 8'h7E, 8'h00, 8'h01, 8'h42, 8'hBD, 8'h33};
        logic [7:0] b;
        bit hit = 0;
        rxq.delete();
        offer(8'h3C);
        master_i.gap = 30;
        // One frame, nothing queued behind it
        master_i.sel(1'b0);
        foreach (fr[k]) begin
            master_i.xfer(fr[k], 8, b);
            hit |= (b === 8'h3C);
        end
        master_i.sel(1'b1);
        repeat (8) @(negedge sys_clk);
        `check("frame count", 5, rxq.size())
        foreach (rxq[k]) `check("frame byte", fr[k + 1], rxq[k])
        `check("tx during rx", 1'b1, hit)
    endtask
    // A kept half byte would join the next one into a start delimiter
    task automatic t_partial();
        logic [7:0] b;
        rxq.delete();
        master_i.sel(1'b0);
        master_i.xfer(8'h7E, 4, b);
        master_i.sel(1'b1);
        @(negedge sys_clk);
        `check("out released", 1'b0, sout_en)
        master_i.sel(1'b0);
        master_i.xfer(8'hE7, 8, b);
        master_i.sel(1'b1);
        repeat (8) @(negedge sys_clk);
        `check("partial dropped", 0, rxq.size())
        out_f = 1'b0;
        master_i.sel(1'b0);
        @(negedge sys_clk);
        `check("out pin unused", 1'b0, sout_en)
        master_i.sel(1'b1);
        @(negedge sys_clk);
        out_f = 1'b1;
    endtask
    // Columns: request pin use, select pin use, request level, select level, sleep
    task automatic t_sleep();
        logic [4:0] tbl[5] = '{5'b11101, 5'b11010, 5'b01111, 5'b01100, 5'b00110};
        mode = 1'b1;
        foreach (tbl[k]) begin
            @(negedge sys_clk);
            {slp_f, sel_f, gio} = tbl[k][4:2];
            master_i.sel(tbl[k][1]);
            repeat (8) @(negedge sys_clk);
            `check("pin sleep", tbl[k][0], slp)
        end
        mode = 1'b0;
        sel_f = 1'b1;
        master_i.sel(1'b1);
    endtask
    task automatic t_uart();
        logic [7:0] b;
        @(negedge sys_clk);
        uart_en = 1'b1;
        attn_f = 1'b0;
        do_reset();
        uart_in = 1'b1;
        @(negedge sys_clk);
        uart_in = 1'b0;
        master_i.sel(1'b0);
        master_i.xfer(8'h7E, 8, b);
        @(negedge sys_clk);
        `check("miso quiet", 1'b0, sout_en)
        master_i.sel(1'b1);
        repeat (4) @(negedge sys_clk);
        `check("uart kept", 1'b1, uart_act)
        `check("spi locked out", 1'b0, spi_act)
        `check("attention unused", 1'b1, attn_n)
        // Any serial pin that is not a peripheral disables the port after reset
        for (int k = 0; k < 2; k++) begin
            {in_f, clk_f} = (k == 0) ? 2'b01 : 2'b10;
            do_reset();
            `check("spi disabled", 1'b0, spi_act)
            `check("uart fallback", 1'b1, uart_act)
            `check("no take when off", 1'b0, tx_ready)
        end
    endtask
    initial begin
        do_reset();
        t_send();
        t_duplex();
        t_partial();
        t_sleep();
        t_uart();
        stop_test();
    end
endmodule
